// >>> src/capture_compare_pwm_pair.sv
// top of the capture/compare/pulse-width unit pair with its registers
`timescale 1ns/1ps
module capture_compare_pwm_pair
    import ccpp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] first_timebase,
    input wire logic [7:0] period_timebase,
    input wire logic [1:0] period_fine,
    input wire logic period_event,
    output logic first_timebase_clear,
    input wire logic unit_a_pin_in,
    output logic unit_a_pin_out,
    output logic unit_a_pin_oe,
    input wire logic unit_b_pin_in,
    output logic unit_b_pin_out,
    output logic unit_b_pin_oe,
    output logic unit_a_match_flag,
    output logic unit_b_match_flag
);
    logic [5:0] ctrl [2]; // duty_low_bits and unit_mode_select per unit
    logic [15:0] unit_value_register [2]; // compare value, capture, duty
    logic [5:0] next_ctrl [2];
    logic [15:0] next_value [2];
    logic [1:0] cap;
    logic [1:0] hit;
    logic [1:0] pin_in;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [7:0] next_rdata;
    assign pin_in = {unit_b_pin_in, unit_a_pin_in};

    // one unit per index; both read the same timebase ports
    for (genvar i = 0; i < 2; i++) begin : g_unit
        logic [2:0] base;
        assign base = (i == 0) ? OFS_CTRL_A : OFS_CTRL_B;
        ccpp_unit u_unit (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .mode(ctrl[i][CTRL_MODE_LSB +: 4]),
            .value(unit_value_register[i]),
            .duty_low_bits(ctrl[i][CTRL_DUTY_LSB +: 2]),
            .first_timebase(first_timebase),
            .period_timebase(period_timebase),
            .period_fine(period_fine),
            .period_event(period_event),
            .pin_in(pin_in[i]),
            .pin_out(pin_out[i]),
            .pin_oe(pin_oe[i]),
            .capture_pulse(cap[i]),
            .match_pulse(hit[i])
        );
        // register writes; a capture beats a software write in one cycle
        always_comb begin
            next_ctrl[i] = ctrl[i];
            next_value[i] = unit_value_register[i];
            if (reg_wr && reg_addr == base) begin
                next_ctrl[i] = reg_wdata[5:0];
            end
            if (reg_wr && reg_addr == base + 3'h1) begin
                next_value[i][7:0] = reg_wdata;
            end
            if (reg_wr && reg_addr == base + 3'h2) begin
                next_value[i][15:8] = reg_wdata;
            end
            if (cap[i]) begin
                next_value[i] = first_timebase;
            end
        end
        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                ctrl[i] <= CTRL_RESET;
                unit_value_register[i] <= VALUE_RESET;
            end else begin
                ctrl[i] <= next_ctrl[i];
                unit_value_register[i] <= next_value[i];
            end
        end
    end

    assign unit_a_pin_out = pin_out[0];
    assign unit_b_pin_out = pin_out[1];
    assign unit_a_pin_oe = pin_oe[0];
    assign unit_b_pin_oe = pin_oe[1];
    // set pulses for the outside flag register
    assign unit_a_match_flag = hit[0];
    assign unit_b_match_flag = hit[1];

    // in unit_b trigger mode a match of either unit clears the shared first timebase
    logic b_trigger;
    assign b_trigger = (ctrl[1][CTRL_MODE_LSB +: 4] == MODE_CMP_TRIGGER);
    // a pulse-width unit never raises hit, so it cannot clear the timer
    assign first_timebase_clear = b_trigger && (hit[0] || hit[1]);

    // read mux, data stands only in the cycle after the strobe
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL_A: next_rdata = {2'b00, ctrl[0]};
                OFS_VAL_A_LO: next_rdata = unit_value_register[0][7:0];
                OFS_VAL_A_HI: next_rdata = unit_value_register[0][15:8];
                OFS_CTRL_B: next_rdata = {2'b00, ctrl[1]};
                OFS_VAL_B_LO: next_rdata = unit_value_register[1][7:0];
                OFS_VAL_B_HI: next_rdata = unit_value_register[1][15:8];
                default: next_rdata = 8'h00; // unmapped reads zero
            endcase
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // fields seen by the checks below
    logic [3:0] mode_a; // unit_mode_select of unit_a
    logic [3:0] mode_b; // unit_mode_select of unit_b
    logic [9:0] duty_a; // ten-bit duty of unit_a
    logic [9:0] duty_b; // ten-bit duty of unit_b
    assign mode_a = ctrl[0][CTRL_MODE_LSB +: 4];
    assign mode_b = ctrl[1][CTRL_MODE_LSB +: 4];
    assign duty_a = {unit_value_register[0][7:0],
                     ctrl[0][CTRL_DUTY_LSB +: 2]};
    assign duty_b = {unit_value_register[1][7:0],
                     ctrl[1][CTRL_DUTY_LSB +: 2]};

    // a capture strobe lands the running count in the unit's value
    a_capture_value: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        cap[0] |=> unit_value_register[0] == $past(first_timebase))
        else $error("capture did not record the timebase");
    a_capture_b: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        cap[1] |=> unit_value_register[1] == $past(first_timebase))
        else $error("unit_b capture did not record the timebase");
    // two captures in one cycle see the very same count
    a_shared_count: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        cap[0] && cap[1]
        |=> unit_value_register[0] == unit_value_register[1])
        else $error("units captured different counts");
    // a fresh rising edge captures at once in every-edge mode
    a_rise_capture: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode_a == MODE_CAP_RISE && unit_a_pin_in && !$past(unit_a_pin_in)
        |-> cap[0])
        else $error("rising edge missed");

    // the trigger clears the shared count and never drives its pin
    a_trigger_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        b_trigger && hit[1] |-> first_timebase_clear)
        else $error("trigger match did not clear timebase");
    a_a_clears: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        b_trigger && hit[0] |-> first_timebase_clear)
        else $error("unit_a match did not clear timebase");
    a_trigger_pin: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        b_trigger |-> !unit_b_pin_oe)
        else $error("trigger mode drove the unit_b pin");
    a_no_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        !b_trigger |-> !first_timebase_clear)
        else $error("timebase cleared without trigger");
    // a pulse-width unit neither matches nor captures
    a_pwm_quiet: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode_a[3:2] == 2'b11 |-> !hit[0] && !cap[0])
        else $error("pulse-width unit_a raised a match or capture");
    a_pwm_quiet_b: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode_b[3:2] == 2'b11 |-> !hit[1] && !cap[1])
        else $error("pulse-width unit_b raised a match or capture");
    // a unit switched off drives nothing and flags nothing
    a_off_quiet: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode_a == MODE_OFF
        |-> !unit_a_pin_oe && !unit_a_match_flag && !cap[0])
        else $error("unit_a active while switched off");
    // one period event starts the high phase of both pulse units
    a_pwm_together: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode_a[3:2] == 2'b11 && mode_b[3:2] == 2'b11 && period_event
        && duty_a != 10'h000 && duty_b != 10'h000
        |=> pin_out[0] && pin_out[1])
        else $error("pulse units did not start together");
    a_edges_aligned: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode_a[3:2] == 2'b11 && mode_b[3:2] == 2'b11 && $stable(ctrl[0])
        && $stable(ctrl[1]) |-> $rose(pin_out[0]) == $rose(pin_out[1])
        || !$past(period_event))
        else $error("pulse rising edges not aligned");
    // control readback carries the duty low bits beside the mode
    a_read_ctrl: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        $past(reg_rd) && $past(reg_addr) == OFS_CTRL_A
        |-> reg_rdata == {2'b00, $past(ctrl[0])})
        else $error("control readback lost a field");
    // a write to the low value byte leaves the high byte alone
    a_write_low: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        reg_wr && reg_addr == OFS_VAL_A_LO && !cap[0]
        |=> unit_value_register[0][7:0] == $past(reg_wdata)
        && unit_value_register[0][15:8]
        == $past(unit_value_register[0][15:8]))
        else $error("low byte write disturbed the value");

    // main scenarios worth seeing once
    c_capture_a: cover property (@(posedge clk_sys) disable iff (!rst_b)
        cap[0]);
    c_compare_a: cover property (@(posedge clk_sys) disable iff (!rst_b)
        hit[0] && !b_trigger);
    c_trigger: cover property (@(posedge clk_sys) disable iff (!rst_b)
        first_timebase_clear);
    c_both_pwm: cover property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(pin_out[0]) && $rose(pin_out[1]));
endmodule : capture_compare_pwm_pair

// >>> src/ccpp_pkg.sv
// shared constants of the capture/compare/pulse-width unit pair
package ccpp_pkg;
    // unit_mode_select codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_TRIGGER = 4'hb;
    localparam logic [3:0] MODE_PWM = 4'hc;
    // prescaler terminal counts for divided capture
    localparam logic [3:0] PRESC_LAST4 = 4'h3;
    localparam logic [3:0] PRESC_LAST16 = 4'hf;
    // register offsets
    localparam logic [2:0] OFS_CTRL_A = 3'h0;
    localparam logic [2:0] OFS_VAL_A_LO = 3'h1;
    localparam logic [2:0] OFS_VAL_A_HI = 3'h2;
    localparam logic [2:0] OFS_CTRL_B = 3'h3;
    localparam logic [2:0] OFS_VAL_B_LO = 3'h4;
    localparam logic [2:0] OFS_VAL_B_HI = 3'h5;
    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DUTY_LSB = 4;
    // reset values
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
endpackage : ccpp_pkg

// >>> src/ccpp_unit.sv
// one capture/compare/pulse-width unit
`timescale 1ns/1ps
module ccpp_unit
    import ccpp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [3:0] mode,
    input wire logic [15:0] value,
    input wire logic [1:0] duty_low_bits,
    input wire logic [15:0] first_timebase,
    input wire logic [7:0] period_timebase,
    input wire logic [1:0] period_fine,
    input wire logic period_event,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic capture_pulse,
    output logic match_pulse
);
    // mode decode
    logic is_cap;
    logic is_cmp;
    logic is_pwm;
    assign is_cap = (mode[3:2] == 2'b01);
    assign is_cmp = (mode == MODE_CMP_TOGGLE) || (mode == MODE_CMP_SET) ||
                    (mode == MODE_CMP_TRIGGER);
    assign is_pwm = (mode[3:2] == 2'b11);

    logic pin_prev; // last pin level, for edge detection
    logic [3:0] presc; // rising-edge prescaler
    logic cmp_prev; // equality seen last cycle
    logic [9:0] duty_lat; // duty latched at period start
    logic next_pin_prev;
    logic [3:0] next_presc;
    logic next_cmp_prev;
    logic [9:0] next_duty_lat;
    logic next_pin_out;

    logic rise;
    logic fall;
    logic cmp_eq;
    logic [9:0] duty;
    assign rise = pin_in && !pin_prev;
    assign fall = !pin_in && pin_prev;
    assign cmp_eq = (first_timebase == value);
    assign duty = {value[7:0], duty_low_bits};

    // event decode: capture counts on the first timebase
    always_comb begin
        capture_pulse = 1'b0;
        case (mode)
            MODE_CAP_FALL: capture_pulse = fall;
            MODE_CAP_RISE: capture_pulse = rise;
            MODE_CAP_RISE4: capture_pulse = rise && (presc == PRESC_LAST4);
            MODE_CAP_RISE16: capture_pulse = rise && (presc == PRESC_LAST16);
            default: capture_pulse = 1'b0;
        endcase
        // only the first cycle of equality counts, a stalled timer fires once
        match_pulse = is_cmp && cmp_eq && !cmp_prev;
    end

    // next state of the unit
    always_comb begin
        next_pin_prev = pin_in;
        next_presc = presc;
        next_cmp_prev = cmp_eq;
        next_duty_lat = duty_lat;
        next_pin_out = pin_out;
        if (mode == MODE_OFF) begin
            // off clears all internal state except pin_prev, which keeps following the pin
            next_presc = 4'h0;
            next_cmp_prev = 1'b0;
            next_duty_lat = 10'h000;
            next_pin_out = 1'b0;
        end else if (is_cap) begin
            if (rise && (mode == MODE_CAP_RISE4 || mode == MODE_CAP_RISE16))
            begin
                next_presc = capture_pulse ? 4'h0 : presc + 4'h1;
            end
        end else if (is_cmp) begin
            if (match_pulse && mode == MODE_CMP_TOGGLE) begin
                next_pin_out = !pin_out;
            end else if (match_pulse && mode == MODE_CMP_SET) begin
                next_pin_out = 1'b1;
            end
        end else if (is_pwm) begin
            // every unit sees the same period event, so edges line up
            if (period_event) begin
                next_duty_lat = duty;
                next_pin_out = (duty != 10'h000);
            end else if (pin_out &&
                         {period_timebase, period_fine} == duty_lat) begin
                next_pin_out = 1'b0;
            end
        end
    end

    // state registers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pin_prev <= 1'b0;
            presc <= 4'h0;
            cmp_prev <= 1'b0;
            duty_lat <= 10'h000;
            pin_out <= 1'b0;
        end else begin
            pin_prev <= next_pin_prev;
            presc <= next_presc;
            cmp_prev <= next_cmp_prev;
            duty_lat <= next_duty_lat;
            pin_out <= next_pin_out;
        end
    end

    // the pin is driven in pulse-width mode and in the compare modes other than trigger
    assign pin_oe = (is_cmp && mode != MODE_CMP_TRIGGER) || is_pwm;

    a_off_clears: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode == MODE_OFF |=> !pin_out && presc == 4'h0)
        else $error("unit state not cleared while off");
    a_pwm_start: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        is_pwm && period_event && duty != 10'h000 |=> pin_out)
        else $error("pulse did not start at period event");
    a_set_match: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode == MODE_CMP_SET && match_pulse |=> pin_out)
        else $error("set-on-match did not raise the pin");
    a_toggle_match: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode == MODE_CMP_TOGGLE && match_pulse && $stable(mode)
        |=> pin_out != $past(pin_out))
        else $error("toggle-on-match did not toggle");
    a_fall_capture: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode == MODE_CAP_FALL && pin_prev && !pin_in |-> capture_pulse)
        else $error("falling edge missed");
    c_pwm_pulse: cover property (@(posedge clk_sys) disable iff (!rst_b)
        is_pwm && pin_out ##1 !pin_out);
endmodule : ccpp_unit

// >>> testbench/capture_compare_pwm_pair_tb.sv
// self-checking bench of the unit pair
`timescale 1ns/1ps
module capture_compare_pwm_pair_tb;
    import ccpp_pkg::*;
    logic clk_sys, rst_b, reg_wr, reg_rd, per_ev, clr, ext_a, ext_b;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, tb2;
    logic [15:0] tb1;
    logic [1:0] fine;
    logic a_in, a_out, a_oe, b_in, b_out, b_oe, a_flag, b_flag;
    int miscompares = 0;
    int checked = 0;
    capture_compare_pwm_pair u_capture_compare_pwm_pair (.clk_sys(clk_sys),
        .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .first_timebase(tb1), .period_timebase(tb2), .period_fine(fine),
        .period_event(per_ev), .first_timebase_clear(clr),
        .unit_a_pin_in(a_in), .unit_a_pin_out(a_out), .unit_a_pin_oe(a_oe),
        .unit_b_pin_in(b_in), .unit_b_pin_out(b_out), .unit_b_pin_oe(b_oe),
        .unit_a_match_flag(a_flag), .unit_b_match_flag(b_flag));
    ccpp_partner u_ccpp_partner (.clk_sys(clk_sys), .rst_b(rst_b),
        .first_timebase_clear(clr), .ext_a(ext_a), .ext_b(ext_b),
        .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
        .first_timebase(tb1), .period_timebase(tb2), .period_fine(fine),
        .period_event(per_ev), .a_in(a_in), .b_in(b_in));
    // 100 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic rdv(input logic [2:0] lo, output logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 3'h1, v[15:8]);
    endtask : rdv
    task automatic t_regs;
        logic [7:0] d;
        rd(OFS_CTRL_A, d);
        chk({8'h00, d}, 16'h0000);
        wr(OFS_CTRL_A, 8'hf0);
        rd(OFS_CTRL_A, d);
        chk({8'h00, d}, 16'h0030);
        rd(3'h6, d);
        chk({8'h00, d}, 16'h0000);
        wr(OFS_CTRL_A, 8'h00);
    endtask : t_regs
    // n edges of the chosen kind; only the last may capture
    task automatic t_cap(input logic [3:0] m, input int n);
        logic act;
        logic [15:0] v0, v, exp;
        act = (m != MODE_CAP_FALL);
        ext_a <= ~act;
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_CTRL_A, {4'h0, m});
        rdv(OFS_VAL_A_LO, v0);
        for (int i = 0; i < n; i++) begin
            if (i == n - 1) begin
                rdv(OFS_VAL_A_LO, v);
                chk(v, v0);
            end
            @(posedge clk_sys);
            ext_a <= ~act;
            repeat (2) @(posedge clk_sys);
            ext_a <= act;
            // the edge is seen in this cycle, so this count is captured
            #1;
            exp = tb1;
        end
        rdv(OFS_VAL_A_LO, v);
        chk(v, exp);
    endtask : t_cap
    // program a match ahead and wait for its flag
    task automatic hit(input logic [2:0] lo, input logic want_clr);
        logic [15:0] t;
        t = tb1 + 16'h0030;
        wr(lo, t[7:0]);
        wr(lo + 3'h1, t[15:8]);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys);
            #1;
            if ((lo == OFS_VAL_A_LO ? a_flag : b_flag) === 1'b1) break;
        end
        chk(tb1, t);
        chk({15'h0000, clr}, {15'h0000, want_clr});
        // the pin follows the match one edge later
        @(posedge clk_sys);
        #1;
    endtask : hit
    task automatic t_cmp;
        wr(OFS_CTRL_A, {4'h0, MODE_CMP_SET});
        hit(OFS_VAL_A_LO, 1'b0);
        chk({14'h0000, a_oe, a_out}, 16'h0003);
        wr(OFS_CTRL_A, 8'h00);
        @(posedge clk_sys);
        #1;
        chk({14'h0000, a_oe, a_out}, 16'h0000);
        wr(OFS_CTRL_A, {4'h0, MODE_CMP_TOGGLE});
        hit(OFS_VAL_A_LO, 1'b0);
        chk({14'h0000, a_oe, a_out}, 16'h0003);
        hit(OFS_VAL_A_LO, 1'b0);
        chk({14'h0000, a_oe, a_out}, 16'h0002);
    endtask : t_cmp
    task automatic t_trig;
        wr(OFS_CTRL_B, {4'h0, MODE_CMP_TRIGGER});
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_CTRL_A, {4'h0, MODE_CMP_SET});
        hit(OFS_VAL_A_LO, 1'b1);
        chk({15'h0000, b_oe}, 16'h0000);
        hit(OFS_VAL_B_LO, 1'b1);
    endtask : t_trig
    task automatic ev;
        for (int i = 0; i < 300; i++) begin
            @(posedge clk_sys);
            #1;
            if (per_ev === 1'b1) break;
        end
    endtask : ev
    // duty a = 0x015, duty b = 0x02a; high for duty plus one cycles
    task automatic t_pwm;
        int ha, hb;
        // unit_a leaves compare with its pin high; off clears it first
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_VAL_A_LO, 8'h05);
        wr(OFS_CTRL_A, 8'h1c);
        wr(OFS_VAL_B_LO, 8'h0a);
        wr(OFS_CTRL_B, 8'h2c);
        repeat (3) ev();
        @(posedge clk_sys);
        #1;
        chk({12'h000, a_oe, b_oe, a_out, b_out}, 16'h000f);
        ha = 0;
        hb = 0;
        for (int i = 0; i < 64; i++) begin
            ha += a_out;
            hb += b_out;
            @(posedge clk_sys);
            #1;
        end
        chk(ha[15:0], 16'h0016);
        chk(hb[15:0], 16'h002b);
    endtask : t_pwm
    task automatic results;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    // watchdog, well beyond the several hundred cycles needed
    initial begin
        #200us;
        miscompares++;
        results();
    end
    initial begin
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ext_a = 1'b0;
        ext_b = 1'b0;
        rst_b = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs();
        t_cap(MODE_CAP_FALL, 1);
        t_cap(MODE_CAP_RISE, 1);
        t_cap(MODE_CAP_RISE4, 4);
        t_cap(MODE_CAP_RISE16, 16);
        t_cmp();
        t_trig();
        t_pwm();
        results();
    end
endmodule : capture_compare_pwm_pair_tb

// >>> testbench/ccpp_partner.sv
// timer and pin model standing outside the unit pair
`timescale 1ns/1ps
module ccpp_partner #(
    parameter logic [9:0] PERIOD_LAST = 10'h03f
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic first_timebase_clear,
    input wire logic ext_a,
    input wire logic ext_b,
    input wire logic a_out,
    input wire logic a_oe,
    input wire logic b_out,
    input wire logic b_oe,
    output logic [15:0] first_timebase,
    output logic [7:0] period_timebase,
    output logic [1:0] period_fine,
    output logic period_event,
    output logic a_in,
    output logic b_in
);
    logic [9:0] per; // period count, fine bits at the bottom
    // first timebase runs free; the trigger pulse zeroes it
    always_ff @(posedge clk_sys) begin
        if (!rst_b || first_timebase_clear) begin
            first_timebase <= 16'h0000;
        end else begin
            first_timebase <= first_timebase + 16'h0001;
        end
    end
    // period count wraps after its last value
    always_ff @(posedge clk_sys) begin
        if (!rst_b || per == PERIOD_LAST) begin
            per <= 10'h000;
        end else begin
            per <= per + 10'h001;
        end
    end
    // event stands in the last cycle of each period
    assign period_event = (per == PERIOD_LAST);
    assign {period_timebase, period_fine} = per;
    // a driven pin reads back its own level, else the outside level
    assign a_in = a_oe ? a_out : ext_a;
    assign b_in = b_oe ? b_out : ext_b;
endmodule : ccpp_partner
